// *** tb/swd_host.sv ***
// host model: three-wire serial master and the shared data wire
`timescale 1ns/100ps
module swd_host (
  output logic cs,
  output logic sclk,
  output logic io_in,
  input wire logic io_out,
  input wire logic io_oe
);
  logic h_oe = 0;
  logic h_d = 0;
  logic last = 0;
  // an undriven wire shows the inverse, never a stale copy
  assign io_in = io_oe ? io_out : (h_oe ? h_d : ~last);
  always @(io_in)
    if (io_oe || h_oe)
      last = io_in;
  initial
  begin
    cs = 0;
    sclk = 0;
  end
  // serial clock runs only inside a frame
  task automatic bitc(input logic b, output logic r);
    h_d = b;
    #160 r = io_in;
    sclk = 1;
    #160 sclk = 0;
  endtask
  task automatic xfer(input logic [7:0] cmd, input logic [7:0] wd,
    input int n, output logic [31:0] rd);
    logic r;
    rd = 32'h00000000;
    #13 cs = 1;
    h_oe = 1;
    for (int i = 0; i < 8; i++)
      bitc(cmd[i], r);
    h_oe = cmd[7];
    for (int i = 0; i < 8 * n; i++)
    begin
      bitc(wd[i % 8], r);
      rd[i] = r;
    end
    #160 cs = 0;
    h_oe = 0;
    #400;
  endtask
endmodule

// *** tb/swd_top_chk.sv ***
// port assertions for the supervisor and serial port
`timescale 1ns/100ps
`include "swd_params.svh"
module swd_top_chk #(
  parameter logic [14:0] TICK_CYC = 15'h000A,
  parameter logic [17:0] CONV_CYC = 18'h00190,
  parameter logic [13:0] FIRST_CYC = 14'h0028
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic vcc_ok,
  input wire logic osc_running,
  input wire logic rst_n_in,
  input wire logic rst_n_out,
  input wire logic rst_n_oe,
  input wire logic watchdog_strobe_n,
  input wire logic cs,
  input wire logic sclk,
  input wire logic io_in,
  input wire logic io_out,
  input wire logic io_oe,
  input wire logic [1:0] analog_in_sel,
  input wire logic [7:0] adc_sample
);
  // one tick of prescaler jitter allowed
  localparam int HOLD_MIN = (int'(`SWD_HOLD_MS) - 1) * int'(TICK_CYC);
  logic [19:0] hi_cnt_r;
  always_ff @(posedge mclk)
    if (reset || !rst_n_oe)
      hi_cnt_r <= 20'h00000;
    else if (hi_cnt_r != 20'hFFFFF)
      hi_cnt_r <= hi_cnt_r + 20'h00001;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);
  a_hold_min: assert property ($fell(rst_n_oe) |-> hi_cnt_r >= HOLD_MIN)
    else $error("reset drive too short");
  a_power_hold: assert property ($fell(reset) |-> rst_n_oe [*8])
    else $error("reset drive missing after power-up");
  a_vcc_drive: assert property (!vcc_ok [*4] |-> rst_n_oe)
    else $error("no reset drive with bad supply");
  a_button_drive: assert property
    ($fell(rst_n_in) && !rst_n_oe |-> ##[1:6] rst_n_oe)
    else $error("button press not debounced");
  a_io_float: assert property (!cs [*5] |-> !io_oe)
    else $error("data pin driven without select");
  a_oe_with_cs: assert property ($rose(io_oe) |-> cs)
    else $error("data pin enabled outside frame");
  a_out_on_fall: assert property
    (io_oe && $changed(io_out) |-> !$past(sclk))
    else $error("read bit changed off falling edge");
  a_sel_by_write: assert property ($changed(analog_in_sel) |-> cs)
    else $error("input select changed outside write");
  c_release: cover property ($fell(rst_n_oe));
  c_read: cover property ($rose(io_oe));
  c_select: cover property ($changed(analog_in_sel));
endmodule
bind swd_top swd_top_chk #(.TICK_CYC(TICK_CYC), .CONV_CYC(CONV_CYC),
  .FIRST_CYC(FIRST_CYC)) swd_top_chk_i (.mclk(mclk), .reset(reset),
  .vcc_ok(vcc_ok), .osc_running(osc_running), .rst_n_in(rst_n_in),
  .rst_n_out(rst_n_out), .rst_n_oe(rst_n_oe), .cs(cs), .sclk(sclk),
  .watchdog_strobe_n(watchdog_strobe_n), .io_in(io_in), .io_out(io_out),
  .io_oe(io_oe), .analog_in_sel(analog_in_sel), .adc_sample(adc_sample));

// *** tb/swd_top_test.sv ***
// self-checking bench for supervisor, watchdog and serial port
`timescale 1ns/100ps
module swd_top_test;
  localparam int TI = 10;
  localparam int HOLD = 250 * TI;
  logic mclk = 0, reset = 1, vcc_ok = 1, osc_running = 0;
  logic pb_low = 0, strobe_n = 1;
  logic [7:0] adc_sample = 8'hFF;
  logic [31:0] r;
  wire cs, sclk, io_in, io_out, io_oe, rst_n_out, rst_n_oe, rst_n_in;
  wire [1:0] analog_in_sel;
  int fail_count, cmp_count, cycles;
  // pulled-up reset wire shorted low by the button
  assign rst_n_in = (rst_n_oe ? rst_n_out : 1'b1) & ~pb_low;
  swd_top #(.TICK_CYC(15'h000A), .CONV_CYC(18'h00190),
    .FIRST_CYC(14'h0028)) swd_top_i (.mclk(mclk), .reset(reset),
    .vcc_ok(vcc_ok), .osc_running(osc_running), .rst_n_in(rst_n_in),
    .rst_n_out(rst_n_out), .rst_n_oe(rst_n_oe), .cs(cs), .sclk(sclk),
    .watchdog_strobe_n(strobe_n), .io_in(io_in), .io_out(io_out),
    .io_oe(io_oe), .analog_in_sel(analog_in_sel), .adc_sample(adc_sample));
  swd_host swd_host_i (.cs(cs), .sclk(sclk), .io_in(io_in),
    .io_out(io_out), .io_oe(io_oe));
  always #20 mclk = ~mclk;
  task automatic print_verdict();
    if (fail_count == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 95000)
    begin
      fail_count++;
      print_verdict();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // time until the reset drive reaches v, against exp cycles
  task automatic span(input logic v, input int exp);
    int n;
    n = 0;
    while (rst_n_oe !== v && n < exp + 100)
    begin
      @(posedge mclk);
      n++;
    end
    chk(n > exp - TI - 30 && n < exp + TI + 30, 1);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    swd_host_i.xfer({1'b1, a}, d, 1, r);
  endtask
  task automatic rd(input logic [6:0] a, input int n);
    swd_host_i.xfer({1'b0, a}, 8'h00, n, r);
  endtask
  task automatic strobe();
    cyc(1);
    strobe_n <= 0;
    cyc(4);
    strobe_n <= 1;
  endtask
  function automatic int wd_cyc(input logic [1:0] s);
    return (s == 2'h1 ? 250 : s == 2'h2 ? 500 : 1000) * TI;
  endfunction
  initial
  begin
    logic [1:0] s;
    logic seen;
    void'($urandom(49407));
    cyc(20);
    reset <= 0;
    rd(7'h0A, 4);
    chk(r, 32'h03008000);
    cyc(3000);
    chk(rst_n_oe, 1);
    osc_running <= 1;
    span(0, HOLD);
    span(1, wd_cyc(2'h3));
    span(0, HOLD);
    wr(7'h0B, 8'h40);
    wr(7'h0D, 8'h01);
    rd(7'h0D, 1);
    chk(r[7:0], 8'h03);
    wr(7'h0B, 8'h00);
    for (int i = 1; i < 5; i++)
    begin
      s = i[1:0];
      wr(7'h0D, {6'h00, s});
      strobe();
      cyc(wd_cyc(s) * (50 + $urandom_range(30)) / 100);
      chk(rst_n_oe, 0);
      strobe();
      if (s != 2'h0)
        span(1, wd_cyc(s));
      if (s != 2'h0)
        span(0, HOLD);
    end
    cyc(wd_cyc(2'h3));
    chk(rst_n_oe, 0);
    pb_low <= 1;
    cyc(3);
    pb_low <= 0;
    cyc(10);
    chk(rst_n_oe, 1);
    chk(rst_n_out, 0);
    span(0, HOLD);
    cyc(20);
    pb_low <= 1;
    cyc(HOLD + 500);
    chk(rst_n_oe, 0);
    pb_low <= 0;
    cyc(10);
    chk(rst_n_oe, 1);
    span(0, HOLD);
    vcc_ok <= 0;
    cyc(20);
    chk(rst_n_oe, 1);
    vcc_ok <= 1;
    span(0, HOLD);
    wr(7'h0B, 8'h10);
    chk(analog_in_sel, 2'h1);
    cyc(40);
    rd(7'h0E, 1);
    chk(r[7:0], 8'hFF);
    rd(7'h0C, 1);
    chk(r[7:0], 8'h00);
    cyc(1);
    // never FFh, so a missed update cannot pass unseen
    adc_sample <= 8'($urandom_range(254));
    seen = 1'b0;
    for (int k = 0; k < 20 && !seen; k++)
    begin
      rd(7'h0C, 1);
      seen = r[7];
    end
    chk(seen, 1);
    cyc(50);
    rd(7'h0E, 1);
    chk(r[7:0], adc_sample);
    for (int i = 2; i < 5; i++)
    begin
      wr(7'h0B, {2'b00, i[1:0], 4'h0});
      chk(analog_in_sel, i[1:0]);
    end
    print_verdict();
  end
endmodule

// *** verilog/swd_params.svh ***
// constants for the supervisor, converter scheduler and serial port
`ifndef SWD_PARAMS_SVH
`define SWD_PARAMS_SVH
`define SWD_CLK_MHZ 25
`define SWD_HOLD_MS 10'd250
`define SWD_WD_SHORT_MS 10'd250
`define SWD_WD_MID_MS 10'd500
`define SWD_WD_LONG_MS 10'd1000
`define SWD_CONV_MS 10
`define SWD_FIRST_US 488
`define SWD_CHK_CYC 3'd4
`define SWD_A_CTRL 7'h0B
`define SWD_A_STAT 7'h0C
`define SWD_A_WDOG 7'h0D
`define SWD_A_ADC 7'h0E
`define SWD_A_WRAP 7'h0E
`define SWD_CTRL_RST 8'h80
`define SWD_CTRL_MASK 8'hF0
`define SWD_WD_RST 2'h3
`define SWD_B_OSC 7
`define SWD_B_WP 6
`define SWD_B_AIS_HI 5
`define SWD_B_AIS_LO 4
`define SWD_B_PEND 7
`define SWD_TD_OFF 2'h0
`define SWD_TD_SHORT 2'h1
`define SWD_TD_MID 2'h2
`define SWD_AIS_OFF 2'h0
`define SWD_SYNC_W 15
`endif

// *** verilog/swd_pkg.sv ***
// types shared by the supervisor design
package swd_pkg;
  typedef enum logic [6:0] {
    SV_FAIL = 7'h01,
    SV_OSC = 7'h02,
    SV_HOLD = 7'h04,
    SV_RUN = 7'h08,
    SV_DEB = 7'h10,
    SV_CHK = 7'h20,
    SV_WAIT = 7'h40
  } swd_state_type;
endpackage

// *** verilog/swd_top.sv ***
// supervisor, watchdog, converter scheduler and three-wire register port
//
// Functional notes
// [RQ1] hold reset while supply bad, then 250 ms more after it recovers
// [RQ2] with oscillator stop set, wait for oscillator start, then 250 ms
// [RQ3] outside reset, falling reset line starts a 250 ms debounce drive
// [RQ4] line still low after debounce: wait release, then drive 250 ms
// [RQ5] missing strobe within selected timeout asserts reset
// [RQ6] timeout select 00 off, 01 250 ms, 10 500 ms, 11 1000 ms
// [RQ7] watchdog counts from full period once reset goes inactive
// [RQ8] watchdog defaults to enabled, 1000 ms after power-up
// [RQ9] strobe falling edge before timeout restarts the full period
// [RQ10] watchdog expiry drives reset for 250 ms
// [RQ11] host strobes no slower than the shortest timeout
// [RQ12] nonzero input select gives first result within 488 us
// [RQ13] results refresh every 10 ms; select changes apply next update
// [RQ14] eight-bit result, ground 00h, reference FFh
// [RQ15] pending flag set within 488 us of update, else quiet 244 us
// [RQ16] a started result read blocks updates until it ends or aborts
// [RQ17] host polls pending flag before reading the result
// [RQ18] chip select high starts transfer; low aborts and floats data pin
// [RQ19] inputs sampled on serial clock rise, outputs change on fall
// [RQ20] address and data bytes travel least significant bit first
// [RQ21] first byte is command; top bit 0 read, 1 write
// [RQ22] address increments per data byte, wrapping from 0Eh to 00h
// [RQ23] write lock high ignores serial writes to other registers
// [RQ24] input select 00 off, 01 input 0, 10 input 1, 11 input 2
// [RQ25] all intervals come from a prescaled counter on mclk; the converter scheduler and the settle check count raw mclk cycles instead
`timescale 1ns/100ps
`include "swd_params.svh"
module swd_top #(
  parameter logic [14:0] TICK_CYC = 15'(`SWD_CLK_MHZ * 1000),
  parameter logic [17:0] CONV_CYC = 18'(`SWD_CONV_MS * `SWD_CLK_MHZ * 1000),
  parameter logic [13:0] FIRST_CYC = 14'(`SWD_FIRST_US * `SWD_CLK_MHZ)
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic vcc_ok,
  input wire logic osc_running,
  input wire logic rst_n_in,
  output logic rst_n_out,
  output logic rst_n_oe,
  input wire logic watchdog_strobe_n,
  input wire logic cs,
  input wire logic sclk,
  input wire logic io_in,
  output logic io_out,
  output logic io_oe,
  output logic [1:0] analog_in_sel,
  input wire logic [7:0] adc_sample
);
  import swd_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers; stage three only feeds edge detection
  logic [`SWD_SYNC_W-1:0] raw;
  logic [`SWD_SYNC_W-1:0] s1_r;
  logic [`SWD_SYNC_W-1:0] s2_r;
  logic [`SWD_SYNC_W-1:0] s3_r;
  assign raw = {adc_sample, osc_running, io_in, sclk, cs,
                watchdog_strobe_n, rst_n_in, vcc_ok};

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end
    else
    begin
      s1_r <= raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  logic vcc_s, line_s, cs_s, io_s, osc_s;
  logic [7:0] sample_s;
  logic line_fall, line_rise, stb_fall, sclk_rise, sclk_fall;
  assign vcc_s = s2_r[0];
  assign line_s = s2_r[1];
  assign cs_s = s2_r[3];
  assign io_s = s2_r[5];
  assign osc_s = s2_r[6];
  assign sample_s = s2_r[14:7];
  assign line_fall = s3_r[1] & ~s2_r[1];
  assign line_rise = ~s3_r[1] & s2_r[1];
  assign stb_fall = s3_r[2] & ~s2_r[2];
  assign sclk_rise = ~s3_r[4] & s2_r[4];
  assign sclk_fall = s3_r[4] & ~s2_r[4];

  ////////////////////////////////////////////////////////////////////////////
  // registers held by the serial port
  logic [7:0] ctrl_r;
  logic [1:0] wd_sel_r;
  logic [7:0] adc_result_r;
  logic osc_stop, wp;
  logic pending;
  assign osc_stop = ctrl_r[`SWD_B_OSC];
  assign wp = ctrl_r[`SWD_B_WP];
  assign analog_in_sel = ctrl_r[`SWD_B_AIS_HI:`SWD_B_AIS_LO]; // RQ24

  function automatic logic [7:0] reg_read(input logic [6:0] a);
    logic [7:0] d;
    d = 8'h00;
    case (a)
      `SWD_A_CTRL: d = ctrl_r;
      `SWD_A_STAT: d = {pending, 7'h00};
      `SWD_A_WDOG: d = {6'h00, wd_sel_r};
      `SWD_A_ADC: d = adc_result_r;
      default: d = 8'h00;
    endcase
    return d;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // millisecond prescaler shared by the hold and watchdog timers; the settle check counts raw mclk
  logic [14:0] tick_cnt_r;
  logic tick;
  assign tick = tick_cnt_r == TICK_CYC - 15'h0001; // RQ25

  always_ff @(posedge mclk)
  begin
    if (reset || tick)
      tick_cnt_r <= '0;
    else
      tick_cnt_r <= tick_cnt_r + 15'h0001;
  end

  ////////////////////////////////////////////////////////////////////////////
  // supervisor state machine
  swd_state_type state_r, state_nxt;
  logic [9:0] tmr_r, tmr_nxt, tmr_dec;
  logic [2:0] chk_r, chk_nxt;
  logic [9:0] wd_cnt_r, wd_cnt_nxt, wd_len;
  logic wd_en, wd_expire, drive_nxt, rst_oe_r;

  assign tmr_dec = (tick && tmr_r != 10'h000) ? tmr_r - 10'h001 : tmr_r;
  assign wd_en = wd_sel_r != `SWD_TD_OFF;
  assign wd_len = (wd_sel_r == `SWD_TD_SHORT) ? `SWD_WD_SHORT_MS :
                  (wd_sel_r == `SWD_TD_MID) ? `SWD_WD_MID_MS :
                  `SWD_WD_LONG_MS; // RQ6
  assign wd_expire = wd_en && wd_cnt_r == 10'h000; // RQ5

  always_comb
  begin
    state_nxt = state_r;
    tmr_nxt = tmr_dec;
    chk_nxt = 3'h0;
    if (!vcc_s)
      state_nxt = SV_FAIL; // RQ1
    else
    begin
      case (state_r)
        SV_FAIL:
        begin
          tmr_nxt = `SWD_HOLD_MS;
          state_nxt = osc_stop ? SV_OSC : SV_HOLD; // RQ1
        end
        SV_OSC:
        begin
          // hold time starts only once the oscillator runs
          tmr_nxt = `SWD_HOLD_MS;
          if (osc_s)
            state_nxt = SV_HOLD; // RQ2
        end
        SV_HOLD:
        begin
          if (tmr_r == 10'h000)
            state_nxt = SV_RUN;
        end
        SV_RUN:
        begin
          if (line_fall)
          begin
            state_nxt = SV_DEB; // RQ3
            tmr_nxt = `SWD_HOLD_MS;
          end
          else if (wd_expire)
          begin
            state_nxt = SV_HOLD; // RQ10
            tmr_nxt = `SWD_HOLD_MS;
          end
        end
        SV_DEB:
        begin
          if (tmr_r == 10'h000)
            state_nxt = SV_CHK;
        end
        SV_CHK:
        begin
          // let the pull-up and synchroniser settle before judging
          chk_nxt = chk_r + 3'h1;
          if (chk_r == `SWD_CHK_CYC)
            state_nxt = line_s ? SV_RUN : SV_WAIT; // RQ4
        end
        SV_WAIT:
        begin
          if (line_rise)
          begin
            state_nxt = SV_HOLD; // RQ4
            tmr_nxt = `SWD_HOLD_MS;
          end
        end
        default: state_nxt = SV_FAIL;
      endcase
    end
  end

  assign drive_nxt = !(state_nxt == SV_RUN || state_nxt == SV_CHK ||
                       state_nxt == SV_WAIT);

  // reload whenever reset is active or the strobe falls
  assign wd_cnt_nxt = (state_r != SV_RUN || stb_fall || !wd_en) ? wd_len :
                      tick && wd_cnt_r != 10'h000 ? wd_cnt_r - 10'h001 :
                      wd_cnt_r; // RQ7 RQ9

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      state_r <= SV_FAIL;
      tmr_r <= `SWD_HOLD_MS;
      chk_r <= 3'h0;
      wd_cnt_r <= `SWD_WD_LONG_MS;
      rst_oe_r <= 1'b1;
    end
    else
    begin
      state_r <= state_nxt;
      tmr_r <= tmr_nxt;
      chk_r <= chk_nxt;
      wd_cnt_r <= wd_cnt_nxt;
      rst_oe_r <= drive_nxt;
    end
  end

  // open-drain: the pin only ever pulls low
  assign rst_n_out = 1'b0;
  assign rst_n_oe = rst_oe_r;

  ////////////////////////////////////////////////////////////////////////////
  // three-wire serial port
  logic cmd_phase_r, wr_r;
  logic [6:0] addr_r, addr_inc;
  logic [2:0] bits_r;
  logic [7:0] in_r, in_byte, out_r;
  logic io_out_r, io_oe_r;
  logic byte_done, wr_fire, wr_ok, rd_fall, adc_hold;

  assign in_byte = {io_s, in_r[7:1]}; // RQ20
  assign byte_done = cs_s && sclk_rise && bits_r == 3'h7;
  assign addr_inc = (addr_r == `SWD_A_WRAP) ? 7'h00 : addr_r + 7'h01; // RQ22
  assign wr_fire = byte_done && !cmd_phase_r && wr_r;
  // the lock bit itself stays writable, else the lock could never lift
  assign wr_ok = wr_fire && (!wp || addr_r == `SWD_A_CTRL); // RQ23
  assign rd_fall = cs_s && sclk_fall && !cmd_phase_r && !wr_r; // RQ19
  assign adc_hold = cs_s && !cmd_phase_r && !wr_r &&
                    addr_r == `SWD_A_ADC; // RQ16

  always_ff @(posedge mclk)
  begin
    if (reset || !cs_s)
    begin
      cmd_phase_r <= 1'b1; // RQ18
      wr_r <= 1'b0;
      addr_r <= 7'h00;
      bits_r <= 3'h0;
      in_r <= 8'h00;
      out_r <= 8'h00;
      io_out_r <= 1'b0;
      io_oe_r <= 1'b0; // RQ18
    end
    else if (sclk_rise)
    begin
      in_r <= in_byte; // RQ19
      bits_r <= bits_r + 3'h1;
      if (byte_done && cmd_phase_r)
      begin
        cmd_phase_r <= 1'b0;
        addr_r <= in_byte[6:0];
        wr_r <= in_byte[7]; // RQ21
        out_r <= reg_read(in_byte[6:0]);
      end
      else if (byte_done)
      begin
        addr_r <= addr_inc; // RQ22
        out_r <= reg_read(addr_inc);
      end
    end
    else if (rd_fall)
    begin
      io_out_r <= out_r[0]; // RQ20
      out_r <= {1'b0, out_r[7:1]};
      io_oe_r <= 1'b1;
    end
  end

  assign io_out = io_out_r;
  assign io_oe = io_oe_r;

  ////////////////////////////////////////////////////////////////////////////
  // register writes
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      ctrl_r <= `SWD_CTRL_RST;
      wd_sel_r <= `SWD_WD_RST; // RQ8
    end
    else if (wr_ok && addr_r == `SWD_A_CTRL)
      ctrl_r <= in_byte & `SWD_CTRL_MASK;
    else if (wr_ok && addr_r == `SWD_A_WDOG)
      wd_sel_r <= in_byte[1:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // converter update scheduler
  logic [17:0] conv_cnt_r, conv_cnt_nxt;
  logic conv_on, conv_due, conv_take;
  assign conv_on = analog_in_sel != `SWD_AIS_OFF;
  assign conv_due = conv_cnt_r == 18'h00000;
  assign conv_take = conv_on && conv_due && !adc_hold; // RQ16
  assign pending = conv_on && conv_cnt_r < 18'(FIRST_CYC); // RQ15

  // the select is checked every cycle; off reloads the first-result count
  assign conv_cnt_nxt = !conv_on ? 18'(FIRST_CYC) - 18'h00001 : // RQ12
                        conv_take ? CONV_CYC - 18'h00001 : // RQ13
                        conv_due ? conv_cnt_r :
                        conv_cnt_r - 18'h00001;

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      conv_cnt_r <= 18'(FIRST_CYC) - 18'h00001;
      adc_result_r <= 8'h00;
    end
    else
    begin
      conv_cnt_r <= conv_cnt_nxt;
      if (conv_take)
        adc_result_r <= sample_s; // RQ14
    end
  end
endmodule
